// file: verification/ssadc_ramp_model.sv
`timescale 1ns/1ps
module ssadc_ramp_model (
	input wire logic core_clk,
	input wire logic ramp_reset,
	input wire logic [15:0] trip_level [4],
	output logic [3:0] comp_out
);
	logic [15:0] ramp_ff;
	initial begin
		ramp_ff = 16'h0000;
		comp_out = 4'h0;
	end
	// Ramp time is kept in cycles since the reset pulse fell.
	// Comparators move on the falling edge, as a real analog trip is unrelated
	// to the sampling edge of the design.
	always @(negedge core_clk) begin
		if (ramp_reset) begin
			ramp_ff <= 16'h0000;
			comp_out <= 4'h0;
		end else begin
			if (ramp_ff != 16'hFFFE)
				ramp_ff <= ramp_ff + 16'h0001;
			for (int i = 0; i < 4; i++)
				comp_out[i] <= (ramp_ff >= trip_level[i]);
		end
	end
endmodule // ssadc_ramp_model

// file: verification/tb_single_slope_adc_timer.sv
`timescale 1ns/1ps
module tb_single_slope_adc_timer;
	logic core_clk;
	logic arst_n;
	logic sync_start;
	logic [10:0] sync_width_setting;
	logic [15:0] pwm_period;
	logic double_update_mode;
	logic [15:0] mode_control_word;
	logic [2:0] ramp_current_trim;
	logic [15:0] thr [4];
	logic [3:0] comp;
	logic pwm_cycle_sync, sample_hold_strobe, aux_select_low, aux_select_high;
	logic [2:0] ramp_current;
	logic [11:0] result_first, result_second, result_third, result_auxiliary;
	logic [11:0] conv_count, max_count;
	logic converting;
	int miscompares = 0;
	int num_checks = 0;

	ssadc_timer dut (.core_clk(core_clk), .arst_n(arst_n),
		.sync_start(sync_start), .sync_width_setting(sync_width_setting),
		.pwm_period(pwm_period), .double_update_mode(double_update_mode),
		.mode_control_word(mode_control_word),
		.ramp_current_trim(ramp_current_trim), .comp_first(comp[0]),
		.comp_second(comp[1]), .comp_third(comp[2]),
		.comp_auxiliary(comp[3]), .pwm_cycle_sync(pwm_cycle_sync),
		.sample_hold_strobe(sample_hold_strobe),
		.aux_select_low(aux_select_low), .aux_select_high(aux_select_high),
		.ramp_current(ramp_current), .result_first(result_first),
		.result_second(result_second), .result_third(result_third),
		.result_auxiliary(result_auxiliary), .conv_count(conv_count),
		.max_count(max_count), .converting(converting));
	ssadc_ramp_model front (.core_clk(core_clk), .ramp_reset(pwm_cycle_sync),
		.trip_level(thr), .comp_out(comp));

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic pulse_sync();
		@(negedge core_clk);
		sync_start = 1'b1;
		@(negedge core_clk);
		sync_start = 1'b0;
	endtask

	// Bounded wait: a stuck counter must not hang the run.
	task automatic wait_count(input logic [11:0] v);
		int n;
		n = 0;
		while (!(conv_count >= v) && n < 5000) begin
			n++;
			@(negedge core_clk);
		end
		check("count reached", {15'h0000, n < 5000}, 16'h0001);
	endtask

	task automatic width_case(input logic [10:0] set, input int exp);
		int n;
		n = 0;
		sync_width_setting = set;
		pulse_sync();
		while (pwm_cycle_sync === 1'b1 && n < 2000) begin
			n++;
			@(negedge core_clk);
		end
		check("sync width", 16'(n), 16'(exp));
		check("sample strobe", {15'h0000, sample_hold_strobe}, 16'h0001);
		check("converting", {15'h0000, converting}, 16'h0001);
		check("count start", {4'h0, conv_count}, 16'h0000);
		@(negedge core_clk);
		check("strobe ends", {15'h0000, sample_hold_strobe}, 16'h0000);
		$display("test sync width %0d done", exp);
	endtask

	task automatic capture_case(input logic rate);
		mode_control_word = {8'h00, rate, 7'h00};
		sync_width_setting = 11'h014;
		pwm_period = 16'hFFFF;
		double_update_mode = 1'b0;
		thr = '{16'h0064, 16'h0096, 16'h00C8, 16'hFFFF};
		pulse_sync();
		check("cleared first", {4'h0, result_first}, 16'h0000);
		check("cleared aux", {4'h0, result_auxiliary}, 16'h0000);
		check("count restart", {4'h0, conv_count}, 16'h0000);
		wait_count(12'h12C);
		// The three synchroniser stages add three cycles after the trip.
		check("first trip", {4'h0, result_first},
			rate ? 16'h0067 : 16'h0033);
		check("second step", {4'h0, result_second - result_first},
			rate ? 16'h0032 : 16'h0019);
		check("third step", {4'h0, result_third - result_first},
			rate ? 16'h0064 : 16'h0032);
		check("no trip", {4'h0, result_auxiliary}, 16'h0000);
		$display("test capture rate %0d done", rate);
	endtask

	task automatic max_case(input logic [15:0] per, input logic dbl,
		input logic rate, input logic [11:0] exp);
		pwm_period = per;
		double_update_mode = dbl;
		mode_control_word = {8'h00, rate, 7'h00};
		sync_width_setting = 11'h014;
		pulse_sync();
		check("max count", {4'h0, max_count}, {4'h0, exp});
		$display("test max count %0h done", exp);
	endtask

	task automatic select_case();
		for (int i = 0; i < 8; i++) begin
			mode_control_word = {14'h0000, 2'(i)};
			ramp_current_trim = 3'(i);
			@(negedge core_clk);
			@(negedge core_clk);
			check("aux select", {14'h0000, aux_select_high, aux_select_low},
				{14'h0000, 2'(i)});
			check("ramp current", {13'h0000, ramp_current},
				{13'h0000, 3'(i)});
		end
		$display("test select done");
	endtask

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial begin
		#400000;
		miscompares++;
		tally_and_finish();
	end

	initial begin
		arst_n = 1'b0;
		sync_start = 1'b0;
		sync_width_setting = 11'h014;
		pwm_period = 16'hFFFF;
		double_update_mode = 1'b0;
		mode_control_word = 16'h0080;
		ramp_current_trim = 3'h0;
		thr = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
		repeat (20) @(negedge core_clk);
		arst_n = 1'b1;
		@(negedge core_clk);
		check("idle sync", {15'h0000, pwm_cycle_sync}, 16'h0000);
		check("idle result", {4'h0, result_third}, 16'h0000);
		$display("test reset done");
		width_case(11'h014, 20);
		width_case(11'h008, 8);
		width_case(11'h002, 5);
		width_case(11'h7D0, 1250);
		capture_case(1'b0);
		capture_case(1'b1);
		max_case(16'h012C, 1'b0, 1'b1, 12'h118);
		max_case(16'h012D, 1'b0, 1'b0, 12'h08C);
		max_case(16'h012C, 1'b1, 1'b1, 12'h082);
		max_case(16'h001E, 1'b1, 1'b1, 12'h000);
		max_case(16'h0C80, 1'b1, 1'b1, 12'h62C);
		max_case(16'hFFFF, 1'b0, 1'b0, 12'hFFF);
		max_case(16'h012C, 1'b0, 1'b1, 12'h118);
		wait_count(12'h118);
		repeat (5) @(negedge core_clk);
		check("count holds", {4'h0, conv_count}, 16'h0118);
		select_case();
		tally_and_finish();
	end
endmodule // tb_single_slope_adc_timer

// file: verilog/ssadc_capture.sv
// Functional notes
// - One shared counter feeds four comparator captures converted together.
// - Auxiliary selector: 00 aux0, 01 aux1, 10 aux2, 11 reference calibration.
// - Ramp-start to crossing time becomes a 12-bit count per channel.
// - Each PWM cycle sync resets ramp and counter and starts conversion.
// - Ramp reset pulse width is programmable, held within 0.05 to 12.5 us.
// - Ramp current magnitude is software selectable in eight steps.
// - Rate bit 7 clear counts at half CPU rate, set at full rate.
// - Each result register captures the counter when its comparator trips.
// - Top count is min of 4095 and remaining window over counter tick.
// - Double update mode uses half the PWM period as conversion window.
// - A comparator that never trips leaves its result at zero.
// - Trim code 0x0 gives least ramp current, 0x7 the most, proportionally.
// - Current-sense sample-and-hold samples at the falling sync pulse edge.
`timescale 1ns/1ps
package ssadc_pkg;
	localparam int CNT_W = 12;
	localparam logic [11:0] CNT_TOP = 12'hFFF;
	localparam int NUM_CH = 4;
	localparam int MODE_W = 16;
	localparam int PER_W = 16;
	localparam int TRIM_W = 3;
	localparam int SW_W = 11;
	localparam int RATE_BIT = 7;
	localparam int MUX_LO_BIT = 0;
	localparam int MUX_HI_BIT = 1;
	localparam int CLK_NS = 10;
	localparam int SYNC_MIN_NS = 50;
	localparam int SYNC_MAX_NS = 12500;
	localparam logic [10:0] SYNC_MIN_CYC =
		11'((SYNC_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [10:0] SYNC_MAX_CYC = 11'(SYNC_MAX_NS / CLK_NS);
	typedef enum logic [1:0] {
		SSADC_SEL_AUX0,
		SSADC_SEL_AUX1,
		SSADC_SEL_AUX2,
		SSADC_SEL_CAL
	} ssadc_sel_t;
	typedef enum logic [1:0] {
		SSADC_IDLE,
		SSADC_RAMP_RST,
		SSADC_CONVERT
	} ssadc_state_t;
endpackage

module ssadc_capture (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic comp_raw,
	input wire logic clear,
	input wire logic arm,
	input wire logic [11:0] count,
	output logic [11:0] result,
	output logic tripped
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;
	logic done_ff;
	logic [11:0] res_ff;
	wire agree = (s2_ff == s3_ff);
	wire trip = agree && s2_ff && !level_ff;
	wire take = trip && arm && !done_ff && !clear;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			level_ff <= 1'b0;
		end else begin
			s1_ff <= comp_raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (agree)
				level_ff <= s2_ff;
		end
	end

	// Only the first trip of a conversion counts, so comparator chatter
	// after the crossing cannot move the result.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			res_ff <= 12'h000;
			done_ff <= 1'b0;
		end else if (clear) begin
			res_ff <= 12'h000;
			done_ff <= 1'b0;
		end else if (take) begin
			res_ff <= count;
			done_ff <= 1'b1;
		end
	end

	assign result = res_ff;
	assign tripped = done_ff;

	chk_clear_zeroes: assert property (@(posedge core_clk) disable iff (!arst_n)
		clear |=> (result == 12'h000) && !tripped)
		else $error("result not cleared at conversion start");
	chk_trip_captures: assert property (@(posedge core_clk) disable iff (!arst_n)
		take |=> result == $past(count)
		##1 ($past(clear) || result == $past(count, 2)))
		else $error("result does not hold the count at the trip");
endmodule // ssadc_capture

// file: verilog/ssadc_timer.sv
`timescale 1ns/1ps
module ssadc_timer (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic sync_start,
	input wire logic [ssadc_pkg::SW_W-1:0] sync_width_setting,
	input wire logic [ssadc_pkg::PER_W-1:0] pwm_period,
	input wire logic double_update_mode,
	input wire logic [ssadc_pkg::MODE_W-1:0] mode_control_word,
	input wire logic [ssadc_pkg::TRIM_W-1:0] ramp_current_trim,
	input wire logic comp_first,
	input wire logic comp_second,
	input wire logic comp_third,
	input wire logic comp_auxiliary,
	output logic pwm_cycle_sync,
	output logic sample_hold_strobe,
	output logic aux_select_low,
	output logic aux_select_high,
	output logic [ssadc_pkg::TRIM_W-1:0] ramp_current,
	output logic [11:0] result_first,
	output logic [11:0] result_second,
	output logic [11:0] result_third,
	output logic [11:0] result_auxiliary,
	output logic [11:0] conv_count,
	output logic [11:0] max_count,
	output logic converting
);
	ssadc_pkg::ssadc_state_t state_ff;
	ssadc_pkg::ssadc_state_t nxt_state;
	logic [11:0] cnt_ff;
	logic [11:0] nxt_cnt;
	logic [10:0] width_cnt_ff;
	logic [10:0] nxt_width_cnt;
	logic div_ff;
	logic sync_ff;
	logic sh_ff;
	ssadc_pkg::ssadc_sel_t sel_ff;
	logic [ssadc_pkg::TRIM_W-1:0] trim_ff;
	logic [11:0] max_ff;

	// Clamp the programmed ramp reset width into the legal pulse range.
	wire [10:0] width_req = sync_width_setting;
	wire width_lo = width_req < ssadc_pkg::SYNC_MIN_CYC;
	wire width_hi = width_req > ssadc_pkg::SYNC_MAX_CYC;
	wire [10:0] width_use = width_lo ? ssadc_pkg::SYNC_MIN_CYC :
		(width_hi ? ssadc_pkg::SYNC_MAX_CYC : width_req);

	// Conversion window and the top count it allows.
	wire [15:0] window = double_update_mode ?
		{1'b0, pwm_period[15:1]} : pwm_period;
	wire [15:0] width_ext = {5'h00, width_use};
	wire [15:0] remain = (window > width_ext) ? window - width_ext : 16'h0000;
	wire rate_full = mode_control_word[ssadc_pkg::RATE_BIT];
	wire [15:0] ticks = rate_full ? remain : {1'b0, remain[15:1]};
	wire [15:0] top_ext = {4'h0, ssadc_pkg::CNT_TOP};
	wire [11:0] max_use = (ticks > top_ext) ?
		ssadc_pkg::CNT_TOP : ticks[11:0];

	// Half rate ticks every other cycle of the CPU clock.
	wire tick = rate_full || div_ff;
	wire in_conv = state_ff == ssadc_pkg::SSADC_CONVERT;
	wire in_rst = state_ff == ssadc_pkg::SSADC_RAMP_RST;
	wire at_top = cnt_ff >= max_ff;
	wire width_end = width_cnt_ff == 11'h001;
	wire conv_start = in_rst && width_end && !sync_start;

	wire [1:0] sel_bits = {mode_control_word[ssadc_pkg::MUX_HI_BIT],
		mode_control_word[ssadc_pkg::MUX_LO_BIT]};

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_width_cnt = width_cnt_ff;
		if (sync_start) begin
			nxt_state = ssadc_pkg::SSADC_RAMP_RST;
			nxt_cnt = 12'h000;
			nxt_width_cnt = width_use;
		end else begin
			unique case (state_ff)
				ssadc_pkg::SSADC_IDLE: begin
					nxt_cnt = 12'h000;
				end
				ssadc_pkg::SSADC_RAMP_RST: begin
					nxt_cnt = 12'h000;
					nxt_width_cnt = width_cnt_ff - 11'h001;
					if (width_end)
						nxt_state = ssadc_pkg::SSADC_CONVERT;
				end
				ssadc_pkg::SSADC_CONVERT: begin
					if (tick && !at_top)
						nxt_cnt = cnt_ff + 12'h001;
					// At the top the count simply holds.
				end
				default: begin
					nxt_state = ssadc_pkg::SSADC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ssadc_pkg::SSADC_IDLE;
			cnt_ff <= 12'h000;
			width_cnt_ff <= 11'h000;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			width_cnt_ff <= nxt_width_cnt;
		end
	end

	// The divider restarts with each sync so every conversion sees the
	// same tick phase; the first half-rate tick lands on the second cycle.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			div_ff <= 1'b0;
		else if (sync_start || !in_conv)
			div_ff <= 1'b0;
		else
			div_ff <= !div_ff;
	end

	// The top count is taken once per conversion so a period change in
	// mid-cycle cannot pull the limit below the running count.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			max_ff <= 12'h000;
		else if (sync_start)
			max_ff <= max_use;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_ff <= 1'b0;
			sh_ff <= 1'b0;
		end else begin
			sync_ff <= nxt_state == ssadc_pkg::SSADC_RAMP_RST;
			sh_ff <= conv_start;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sel_ff <= ssadc_pkg::SSADC_SEL_AUX0;
			trim_ff <= '0;
		end else begin
			sel_ff <= ssadc_pkg::ssadc_sel_t'(sel_bits);
			trim_ff <= ramp_current_trim;
		end
	end

	// All four channels share one counter and the same clear.
	wire [3:0] comp_vec = {comp_auxiliary, comp_third, comp_second,
		comp_first};
	wire [11:0] res_vec [ssadc_pkg::NUM_CH];
	wire [3:0] trip_vec;

	genvar gi;
	generate
		for (gi = 0; gi < ssadc_pkg::NUM_CH; gi++) begin : g_ch
			ssadc_capture u_cap (
				.core_clk(core_clk),
				.arst_n(arst_n),
				.comp_raw(comp_vec[gi]),
				.clear(sync_start),
				.arm(in_conv),
				.count(cnt_ff),
				.result(res_vec[gi]),
				.tripped(trip_vec[gi])
			);
		end
	endgenerate

	assign result_first = res_vec[0];
	assign result_second = res_vec[1];
	assign result_third = res_vec[2];
	assign result_auxiliary = res_vec[3];
	assign pwm_cycle_sync = sync_ff;
	assign sample_hold_strobe = sh_ff;
	assign aux_select_low = sel_ff[ssadc_pkg::MUX_LO_BIT];
	assign aux_select_high = sel_ff[ssadc_pkg::MUX_HI_BIT];
	assign ramp_current = trim_ff;
	assign conv_count = cnt_ff;
	assign max_count = max_ff;
	assign converting = in_conv;

	chk_sync_clears_count: assert property (@(posedge core_clk) disable iff (!arst_n)
		sync_start |=> conv_count == 12'h000 && pwm_cycle_sync)
		else $error("sync did not restart the conversion");

	chk_pulse_least_width: assert property (@(posedge core_clk) disable iff (!arst_n)
		$rose(pwm_cycle_sync) |-> pwm_cycle_sync[*5])
		else $error("ramp reset pulse shorter than least width");

	chk_pulse_exact_width: assert property (@(posedge core_clk) disable iff (!arst_n)
		sync_start && sync_width_setting == 11'h008
		##1 (!sync_start && sync_width_setting == 11'h008)[*8]
		|-> pwm_cycle_sync ##1 !pwm_cycle_sync)
		else $error("ramp reset pulse width differs from setting");

	chk_count_limit: assert property (@(posedge core_clk) disable iff (!arst_n)
		conv_count <= max_count)
		else $error("count passed its top");

	chk_hold_at_top: assert property (@(posedge core_clk) disable iff (!arst_n)
		converting && conv_count == max_count && !sync_start
		|=> $stable(conv_count))
		else $error("count moved at its top");

	chk_full_rate: assert property (@(posedge core_clk) disable iff (!arst_n)
		converting && rate_full && conv_count < max_count && !sync_start
		|=> conv_count == $past(conv_count) + 12'h001)
		else $error("full rate count did not step");

	chk_half_rate: assert property (@(posedge core_clk) disable iff (!arst_n)
		(converting && !rate_full && conv_count < 12'h7FF
		&& 12'h002 <= max_count - conv_count && !sync_start)[*3]
		|-> conv_count == $past(conv_count, 2) + 12'h001)
		else $error("half rate count wrong over two cycles");

	chk_window_half: assert property (@(posedge core_clk) disable iff (!arst_n)
		sync_start && double_update_mode && rate_full
		&& pwm_period < 16'h1000 && pwm_period > 16'h0800
		&& width_ext < 16'h0400
		|=> max_count ==
		12'({1'b0, $past(pwm_period[15:1])} - $past(width_ext)))
		else $error("double update window not half period");

	chk_sample_edge: assert property (@(posedge core_clk) disable iff (!arst_n)
		$fell(pwm_cycle_sync) && converting |-> sample_hold_strobe)
		else $error("sample strobe missing at sync falling edge");

	chk_aux_select: assert property (@(posedge core_clk) disable iff (!arst_n)
		##1 {aux_select_high, aux_select_low} == $past(sel_bits))
		else $error("auxiliary selector does not follow mode bits");

	chk_trim_follow: assert property (@(posedge core_clk) disable iff (!arst_n)
		##1 ramp_current == $past(ramp_current_trim))
		else $error("ramp current code does not follow trim");

	cov_full_conversion: cover property (@(posedge core_clk)
		disable iff (!arst_n) sync_start ##[1:300] converting ##1 !sync_start);
	cov_reach_top: cover property (@(posedge core_clk)
		disable iff (!arst_n) converting && conv_count == max_count);
	cov_all_tripped: cover property (@(posedge core_clk)
		disable iff (!arst_n) converting && trip_vec == 4'hF);
	cov_cal_select: cover property (@(posedge core_clk)
		disable iff (!arst_n) sel_ff == ssadc_pkg::SSADC_SEL_CAL && converting);
endmodule // ssadc_timer
